/* dv/ddsw_serial_master.sv */
// behavioural serial master driving frame select, serial clock and data
// assumes one send at a time; timing runs free of the system clock
`default_nettype none

module ddsw_serial_master #(
  parameter realtime HALF = 62.5 // half of the 125 ns serial period
) (
  // serial pins
  output var logic frameSelN,
  output var logic serialClk,
  output var logic serialData
);
  timeunit 1ns;
  timeprecision 100ps;

  // lines idle low between frames, clock stopped
  initial begin
    frameSelN = 1'b0;
    serialClk = 1'b0;
    serialData = 1'b0;
  end

  // n bits msb first, then extra pulses the device must ignore; fewer than 16 pulses in all (n plus extra) aborts
  task automatic send(input logic [15:0] word, input int nBits, input int extra);
    int i;
    #1; // step off the system clock edge
    frameSelN = 1'b1;
    #HALF serialClk = 1'b1;
    #HALF frameSelN = 1'b0;
    for (i = 0; i < nBits + extra; i++) begin
      serialData = (i < nBits) ? word[15 - i] : ~serialData;
      #HALF serialClk = 1'b0;
      #HALF serialClk = 1'b1;
    end
    #HALF frameSelN = 1'b1;
    #HALF serialClk = 1'b0;
    serialData = 1'b0;
    #HALF frameSelN = 1'b0;
  endtask
endmodule

`default_nettype wire

/* dv/ddsw_serial_write_ctrl_chk.sv */
// port-level checker for the serial write control block
// assumes one clk domain with srst; bound onto every instance of the top
`default_nettype none

module ddsw_serial_write_ctrl_chk #(
  parameter int WAKE_CYCLES = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link clock pin and register port
  input wire logic serialClk,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdData,
  // converter side
  input wire logic [7:0] analogOutputFirst,
  input wire logic [7:0] analogOutputSecond,
  input wire logic powerDown,
  input wire logic [1:0] termSelect,
  input wire logic wakeBusy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  logic clkPrev_reg; // raw serial clock one sample ago
  logic [3:0] sinceFall_reg; // cycles since a raw clock fall or a write, saturating
  logic [15:0] busyRun_reg; // length of the running wake interval, wide enough for the default

  // an output may only move shortly after a clock fall or a write; sync delay is about two cycles
  always_ff @(posedge clk) begin
    clkPrev_reg <= serialClk;
    if (srst || regWrite || (clkPrev_reg && !serialClk)) begin
      sinceFall_reg <= 4'h0;
    end else if (sinceFall_reg != 4'hf) begin
      sinceFall_reg <= sinceFall_reg + 4'h1;
    end
  end

  // count busy cycles, cleared whenever the timer is idle
  always_ff @(posedge clk) begin
    if (srst || !wakeBusy) begin
      busyRun_reg <= 16'h0;
    end else begin
      busyRun_reg <= busyRun_reg + 16'h1;
    end
  end

  a_reset_clear: assert property ($fell(srst) |->
    analogOutputFirst == 8'h0 && analogOutputSecond == 8'h0 && !powerDown
    && termSelect == 2'h0 && !wakeBusy) else $error("outputs not cleared by reset");
  a_pd_keeps_codes: assert property ($rose(powerDown) |->
    $stable(analogOutputFirst) && $stable(analogOutputSecond))
    else $error("codes moved on entering power-down");
  // a soft clear lands two cycles after its write strobe, hence the depth of two
  a_wake_start: assert property ($fell(powerDown) && !$past(regWrite, 2) |->
    ##[0:2] wakeBusy) else $error("wake timer did not start");
  a_wake_length: assert property ($fell(wakeBusy) && !powerDown && !$past(regWrite, 2) |->
    busyRun_reg >= WAKE_CYCLES - 1 && busyRun_reg <= WAKE_CYCLES + 1)
    else $error("wake interval has wrong length");
  a_rd_idle_zero: assert property (!regRead |=> regRdData == 16'h0)
    else $error("read data not zero outside a read");
  a_rd_unmapped: assert property (regRead && regAddr == 8'h1c |=> regRdData == 16'h0)
    else $error("unmapped read not zero");
  a_status_mirror: assert property (regRead && regAddr == ddsw_pkg::REG_STATUS |=>
    regRdData[0] == $past(powerDown) && regRdData[2:1] == $past(termSelect))
    else $error("status disagrees with outputs");
  a_out_mirror: assert property (regRead && regAddr == ddsw_pkg::REG_OUTPUT_SECOND |=>
    regRdData == {8'h0, $past(analogOutputSecond)}) else $error("output code readback wrong");
  a_change_cause: assert property (
    $changed(analogOutputFirst) || $changed(analogOutputSecond) || $changed(powerDown)
    |-> sinceFall_reg <= 4'h6) else $error("output changed without a clock fall");
endmodule

bind ddsw_serial_write_ctrl ddsw_serial_write_ctrl_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
  .clk(clk), .srst(srst), .serialClk(serialClk), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .analogOutputFirst(analogOutputFirst),
  .analogOutputSecond(analogOutputSecond), .powerDown(powerDown), .termSelect(termSelect),
  .wakeBusy(wakeBusy));

`default_nettype wire

/* dv/ddsw_serial_write_ctrl_tb.sv */
// self-checking bench: frames from the master model, readback over the register port
// assumes package and design compiled first and the checker bound to the top
`default_nettype none

module ddsw_serial_write_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int WAKE = 8; // shortened wake interval keeps the run brief
  logic clk, srst, regWrite, regRead, powerDown, wakeBusy;
  logic frameSelN, serialClk, serialData;
  logic [7:0] regAddr, outFirst, outSecond;
  logic [15:0] regWrData, regRdData, rd;
  logic [1:0] termSelect;
  int badCount, nChecks, n;
  int cycles = 0;

  ddsw_serial_write_ctrl #(.WAKE_CYCLES(WAKE)) u_dut (.clk(clk), .srst(srst),
    .frameSelN(frameSelN), .serialClk(serialClk), .serialData(serialData),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .analogOutputFirst(outFirst), .analogOutputSecond(outSecond),
    .powerDown(powerDown), .termSelect(termSelect), .wakeBusy(wakeBusy));
  ddsw_serial_master u_master (.frameSelN(frameSelN), .serialClk(serialClk),
    .serialData(serialData));

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle read; data stands only in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // lead bit always zero outside power-down
  function automatic logic [15:0] mk(input logic ch, input logic [1:0] m, input logic [11:0] d);
    return {1'b0, ch, m, d};
  endfunction

  task automatic frame(input logic [15:0] w, input int nBits, input int extra);
    u_master.send(w, nBits, extra);
    repeat (8) @(posedge clk);
  endtask

  task automatic outs(input logic [7:0] a, input logic [7:0] b, input logic pd);
    #1;
    chk("codes", {a, b}, {outFirst, outSecond});
    chk("powerDown", {15'h0, pd}, {15'h0, powerDown});
  endtask

  task automatic t_reset();
    outs(8'h00, 8'h00, 1'b0);
    rd_reg(ddsw_pkg::REG_CTRL, rd);
    chk("ctrl", {15'h0, ddsw_pkg::CTRL_LINK_EN_RESET}, {15'h0, rd[0]});
  endtask

  // every non power-down mode, channel bit both ways, code boundaries
  task automatic t_modes();
    frame(mk(1'b0, ddsw_pkg::MODE_WRITE_ONE, 12'hab5), 16, 0);
    outs(8'h00, 8'h00, 1'b0);
    rd_reg(ddsw_pkg::REG_INPUT_FIRST, rd);
    chk("inputFirst", 16'h00ab, rd);
    frame(mk(1'b1, ddsw_pkg::MODE_WRITE_UPDATE, 12'h34f), 16, 0);
    outs(8'hab, 8'h34, 1'b0);
    frame(mk(1'b0, ddsw_pkg::MODE_WRITE_BOTH, 12'hff0), 16, 0);
    outs(8'hff, 8'hff, 1'b0);
    frame(mk(1'b1, ddsw_pkg::MODE_WRITE_BOTH, 12'h00f), 16, 0);
    outs(8'h00, 8'h00, 1'b0);
  endtask

  // short frame only sets the abort flag; pulses after the sixteenth are dropped
  task automatic t_abort();
    frame(mk(1'b0, ddsw_pkg::MODE_WRITE_BOTH, 12'h550), 15, 0);
    outs(8'h00, 8'h00, 1'b0);
    rd_reg(ddsw_pkg::REG_STATUS, rd);
    chk("abortFlag", 16'h0001, {15'h0, rd[ddsw_pkg::ST_ABORT_BIT]});
    wr_reg(ddsw_pkg::REG_STATUS, 16'h0020);
    rd_reg(ddsw_pkg::REG_STATUS, rd);
    chk("abortCleared", 16'h0000, {15'h0, rd[ddsw_pkg::ST_ABORT_BIT]});
    frame(mk(1'b0, ddsw_pkg::MODE_WRITE_BOTH, 12'h5a0), 16, 4);
    outs(8'h5a, 8'h5a, 1'b0);
  endtask

  // all four lead-bit settings, covering the three termination codes; registers survive
  task automatic t_power_down();
    logic [1:0] lead;
    logic [1:0] term;
    for (int i = 0; i < 4; i++) begin
      lead = i[1:0];
      term = (lead == 2'h1) ? ddsw_pkg::TERM_2K5 : (lead == 2'h2) ? ddsw_pkg::TERM_100K
        : ddsw_pkg::TERM_HIZ;
      frame({lead, ddsw_pkg::MODE_POWER_DOWN, 12'hfff}, 16, 0);
      outs(8'h5a, 8'h5a, 1'b1);
      chk("term", {14'h0, term}, {14'h0, termSelect});
    end
    rd_reg(ddsw_pkg::REG_INPUT_FIRST, rd);
    chk("inputKept", 16'h005a, rd);
  endtask

  // waking write loads one channel; wake interval runs from the sixteenth fall
  task automatic t_wake();
    fork
      u_master.send(mk(1'b0, ddsw_pkg::MODE_WRITE_UPDATE, 12'h7e0), 16, 0);
      begin
        n = 0;
        while (powerDown !== 1'b0 && n < 1000) begin
          @(posedge clk);
          #1 n++;
        end
        n = 0;
        repeat (40) begin
          @(posedge clk);
          #1 n += (wakeBusy === 1'b1) ? 1 : 0;
        end
        chk("wakeLen", 16'h0001, {15'h0, n >= WAKE - 1 && n <= WAKE + 1});
      end
    join
    outs(8'h7e, 8'h5a, 1'b0);
    rd_reg(ddsw_pkg::REG_OUTPUT_SECOND, rd);
    chk("outSecond", 16'h005a, rd);
    rd_reg(8'h1c, rd);
    chk("unmapped", 16'h0000, rd);
    rd_reg(ddsw_pkg::REG_FRAMES, rd);
    chk("frames", 16'h000a, rd);
  endtask

  // link off drops frames; soft clear zeroes codes, power-down and termination
  task automatic t_clear();
    wr_reg(ddsw_pkg::REG_CTRL, 16'h0000);
    frame(mk(1'b0, ddsw_pkg::MODE_WRITE_BOTH, 12'h120), 16, 0);
    outs(8'h7e, 8'h5a, 1'b0);
    wr_reg(ddsw_pkg::REG_CTRL, 16'h0001);
    frame({2'h1, ddsw_pkg::MODE_POWER_DOWN, 12'h000}, 16, 0);
    outs(8'h7e, 8'h5a, 1'b1);
    chk("termSet", 16'h0001, {14'h0, termSelect});
    wr_reg(ddsw_pkg::REG_CTRL, 16'h0003);
    repeat (2) @(posedge clk);
    outs(8'h00, 8'h00, 1'b0);
    chk("termCleared", 16'h0000, {14'h0, termSelect});
    rd_reg(ddsw_pkg::REG_INPUT_SECOND, rd);
    chk("inputCleared", 16'h0000, rd);
  endtask

  initial begin
    srst = 1'b1;
    regAddr = 8'h0;
    regWrData = 16'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    badCount = 0;
    nChecks = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_modes();
    t_abort();
    t_power_down();
    t_wake();
    t_clear();
    close_out();
  end
endmodule

`default_nettype wire

/* verilog/ddsw_pin_sync.sv */
// two-flop synchroniser for a group of pins, with edge pulses on the result
// assumes pins are asynchronous to clk and held at least two clk periods per level
`default_nettype none

module ddsw_pin_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // raw pins
  input wire logic [WIDTH-1:0] pinIn,
  // synchronised level and its edges
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fallPulse,
  output logic [WIDTH-1:0] risePulse
);

  if (WIDTH < 1) begin : g_chk
    $error("ddsw_pin_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_reg; // first stage, read only by the second
  logic [WIDTH-1:0] sync_reg; // second stage
  logic [WIDTH-1:0] prev_reg; // history for edge finding

  // reset to low so a line idling low is not taken for an edge at release
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= pinIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level = sync_reg;
  assign fallPulse = prev_reg & ~sync_reg;
  assign risePulse = ~prev_reg & sync_reg;

endmodule

`default_nettype wire

/* verilog/ddsw_pkg.sv */
// constants, field layouts and types of the dual dac serial write control block
// assumes a 100 MHz system clock; the control block, its checker and bench refer to names here
`default_nettype none

package ddsw_pkg;

  // frame geometry
  localparam int FRAME_BITS = 16;
  localparam int DATA_BITS = 12;
  localparam int CODE_BITS = 8;
  localparam logic [4:0] LAST_BIT_IDX = 5'h0f; // index of the 16th falling edge
  localparam logic [4:0] FIRST_BIT_IDX = 5'h00;

  // one received frame, first bit sent sits at the top
  typedef struct packed {
    logic leadBitHi;          // must be zero; termination high bit in power-down
    logic leadBitLo;          // channel address; termination low bit in power-down
    logic [1:0] opMode;       // op_mode_hi, op_mode_lo
    logic [DATA_BITS-1:0] data; // straight binary, msb first
  } ddsw_frame_t;

  // operating modes
  typedef enum logic [1:0] {
    MODE_WRITE_ONE = 2'h0,
    MODE_WRITE_UPDATE = 2'h1,
    MODE_WRITE_BOTH = 2'h2,
    MODE_POWER_DOWN = 2'h3
  } ddsw_mode_t;

  // output terminations while powered down
  localparam logic [1:0] TERM_HIZ = 2'h0;
  localparam logic [1:0] TERM_2K5 = 2'h1;
  localparam logic [1:0] TERM_100K = 2'h2;

  // receiver states, gray along idle -> shift -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SHIFT = 2'h1,
    ST_DONE = 2'h3
  } ddsw_state_t;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INPUT_FIRST = 8'h08;
  localparam logic [7:0] REG_INPUT_SECOND = 8'h0c;
  localparam logic [7:0] REG_OUTPUT_FIRST = 8'h10;
  localparam logic [7:0] REG_OUTPUT_SECOND = 8'h14;
  localparam logic [7:0] REG_FRAMES = 8'h18;

  // control fields
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam int CTRL_SOFT_CLR_BIT = 1;
  localparam logic CTRL_LINK_EN_RESET = 1'h1;

  // status fields
  localparam int ST_PD_BIT = 0;
  localparam int ST_TERM_LSB = 1;
  localparam int ST_WAKE_BIT = 3;
  localparam int ST_LEAD_ERR_BIT = 4;
  localparam int ST_ABORT_BIT = 5;
  localparam int ST_STATE_LSB = 6;

  // wake interval, typical figure, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_INTERVAL_NS = 6000;
  localparam int WAKE_CYCLES = (WAKE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

`default_nettype wire

/* verilog/ddsw_serial_write_ctrl.sv */
// serial write port and control logic of a dual 8-bit voltage-output converter
// assumes the serial master drives frame select, serial clock and data as
// plain pins asynchronous to clk, and software uses the one-cycle register port
`default_nettype none

module ddsw_serial_write_ctrl #(
  parameter int WAKE_CYCLES = ddsw_pkg::WAKE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial link pins
  input wire logic frameSelN,
  input wire logic serialClk,
  input wire logic serialData,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  // converter side
  output logic [7:0] analogOutputFirst,
  output logic [7:0] analogOutputSecond,
  output logic powerDown,
  output logic [1:0] termSelect,
  output logic wakeBusy
);

  if (WAKE_CYCLES < 1) begin : g_chk
    $error("ddsw_serial_write_ctrl: WAKE_CYCLES must be at least 1");
  end

  // pin indices inside the synchroniser group
  localparam int PIN_SEL = 0;
  localparam int PIN_CLK = 1;
  localparam int PIN_DATA = 2;
  localparam int CODE_LSB = ddsw_pkg::DATA_BITS - ddsw_pkg::CODE_BITS;

  // address hit test, shared by the read and write decoders
  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] offset);
    regHit = (addr == offset);
  endfunction

  // converter code from a frame's data field
  function automatic logic [7:0] frameCode(input ddsw_pkg::ddsw_frame_t f);
    frameCode = f.data[ddsw_pkg::DATA_BITS-1:CODE_LSB];
  endfunction

  // synchronised link pins
  logic [2:0] pinLevel; // synchronised levels
  logic [2:0] pinFall; // one-cycle falling edge pulses
  logic [2:0] pinRise; // one-cycle rising edge pulses

  ddsw_pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk(clk),
    .srst(srst),
    .pinIn({serialData, serialClk, frameSelN}),
    .level(pinLevel),
    .fallPulse(pinFall),
    .risePulse(pinRise)
  );

  // frame select and clock edges as the receiver sees them
  logic selFall;
  logic selRise;
  logic clkFall;
  logic dataBit;

  assign selFall = pinFall[PIN_SEL];
  assign selRise = pinRise[PIN_SEL];
  assign clkFall = pinFall[PIN_CLK];
  assign dataBit = pinLevel[PIN_DATA];

  // control register state
  logic linkEn_reg; // receiver accepts new frames
  logic softClr; // one-cycle software clear of the converter state

  // receiver state
  ddsw_pkg::ddsw_state_t state_reg;
  logic [4:0] bitCnt_reg; // falling edges taken in this frame
  logic [15:0] shift_reg; // input shift register
  logic lastEdge; // this clock fall is the sixteenth
  logic frameDone; // a complete frame is to be executed now
  logic frameAbort; // select rose before the sixteenth fall
  ddsw_pkg::ddsw_frame_t frame; // word as it stands after the last bit
  ddsw_pkg::ddsw_mode_t frameMode;

  // converter state
  logic [7:0] inFirst_reg; // first channel converter register
  logic [7:0] inSecond_reg; // second channel converter register
  logic [7:0] outFirst_reg; // code applied to the first output
  logic [7:0] outSecond_reg; // code applied to the second output
  logic pd_reg;
  logic [1:0] term_reg;
  logic [7:0] nextFirst; // register values after this frame
  logic [7:0] nextSecond;
  logic wakeStart;
  logic wakeRun;

  // status and readback
  logic leadErr_reg; // a non power-down frame arrived with a nonzero first bit
  logic abort_reg; // a frame was cut short
  logic [15:0] frames_reg; // executed frame count, wraps
  logic [15:0] rdData_reg;
  logic [15:0] rdMux;

  assign lastEdge = (state_reg == ddsw_pkg::ST_SHIFT) && clkFall &&
                    (bitCnt_reg == ddsw_pkg::LAST_BIT_IDX);
  // the final fall and the select rise may land in one sample: the fall wins
  assign frameDone = lastEdge;
  assign frameAbort = (state_reg == ddsw_pkg::ST_SHIFT) && selRise && !lastEdge;
  assign frame = ddsw_pkg::ddsw_frame_t'({shift_reg[14:0], dataBit});
  assign frameMode = ddsw_pkg::ddsw_mode_t'(frame.opMode);

  // receiver sequence: idle, shifting, done-and-deaf
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ddsw_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        ddsw_pkg::ST_IDLE: begin
          // only a falling select starts a frame; a line held low does not
          if (selFall && linkEn_reg) begin
            state_reg <= ddsw_pkg::ST_SHIFT;
          end
        end
        ddsw_pkg::ST_SHIFT: begin
          if (lastEdge) begin
            // a rise in the same sample ends the frame at once
            state_reg <= selRise ? ddsw_pkg::ST_IDLE : ddsw_pkg::ST_DONE;
          end else if (selRise) begin
            state_reg <= ddsw_pkg::ST_IDLE;
          end
        end
        ddsw_pkg::ST_DONE: begin
          // clocks and data are ignored here until select goes high
          if (selRise) begin
            state_reg <= ddsw_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= ddsw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // bit counter and shift register; a clock fall in the start sample is
  // dropped, since select was not yet seen low when that edge arrived
  always_ff @(posedge clk) begin
    if (srst) begin
      bitCnt_reg <= ddsw_pkg::FIRST_BIT_IDX;
      shift_reg <= '0;
    end else if (state_reg == ddsw_pkg::ST_IDLE) begin
      bitCnt_reg <= ddsw_pkg::FIRST_BIT_IDX;
    end else if (state_reg == ddsw_pkg::ST_SHIFT && clkFall) begin
      shift_reg <= {shift_reg[14:0], dataBit};
      bitCnt_reg <= bitCnt_reg + 5'h01;
    end
  end

  // register values a frame would leave behind; power-down leaves both alone
  always_comb begin
    nextFirst = inFirst_reg;
    nextSecond = inSecond_reg;
    unique case (frameMode)
      ddsw_pkg::MODE_WRITE_ONE, ddsw_pkg::MODE_WRITE_UPDATE: begin
        if (frame.leadBitLo) begin
          nextSecond = frameCode(frame);
        end else begin
          nextFirst = frameCode(frame);
        end
      end
      ddsw_pkg::MODE_WRITE_BOTH: begin
        nextFirst = frameCode(frame);
        nextSecond = frameCode(frame);
      end
      ddsw_pkg::MODE_POWER_DOWN: begin
        nextFirst = inFirst_reg;
        nextSecond = inSecond_reg;
      end
    endcase
  end

  // converter registers: loaded on every executed frame
  always_ff @(posedge clk) begin
    if (srst || softClr) begin
      inFirst_reg <= '0;
      inSecond_reg <= '0;
    end else if (frameDone) begin
      inFirst_reg <= nextFirst;
      inSecond_reg <= nextSecond;
    end
  end

  // applied output codes: only updating modes move them
  always_ff @(posedge clk) begin
    if (srst || softClr) begin
      outFirst_reg <= '0;
      outSecond_reg <= '0;
    end else if (frameDone && (frameMode == ddsw_pkg::MODE_WRITE_UPDATE ||
                               frameMode == ddsw_pkg::MODE_WRITE_BOTH)) begin
      outFirst_reg <= nextFirst;
      outSecond_reg <= nextSecond;
    end
  end

  // power-down state and termination choice
  always_ff @(posedge clk) begin
    if (srst || softClr) begin
      pd_reg <= 1'b0;
      term_reg <= ddsw_pkg::TERM_HIZ;
    end else if (frameDone) begin
      if (frameMode == ddsw_pkg::MODE_POWER_DOWN) begin
        pd_reg <= 1'b1;
        unique case ({frame.leadBitHi, frame.leadBitLo})
          2'h1: term_reg <= ddsw_pkg::TERM_2K5;
          2'h2: term_reg <= ddsw_pkg::TERM_100K;
          default: term_reg <= ddsw_pkg::TERM_HIZ;
        endcase
      end else begin
        // any other mode recovers; codes it loads apply at recovery only in update and write-both modes
        pd_reg <= 1'b0;
      end
    end
  end

  // wake interval starts at the sixteenth fall of the recovering frame
  assign wakeStart = frameDone && pd_reg &&
                     (frameMode != ddsw_pkg::MODE_POWER_DOWN);

  ddsw_wake_timer #(
    .CYCLES(WAKE_CYCLES)
  ) u_wake_timer (
    .clk(clk),
    .srst(srst),
    .start(wakeStart),
    .abort(softClr || (frameDone && frameMode == ddsw_pkg::MODE_POWER_DOWN)),
    .busy(wakeRun)
  );

  // control register: link enable, self-clearing soft clear
  always_ff @(posedge clk) begin
    if (srst) begin
      linkEn_reg <= ddsw_pkg::CTRL_LINK_EN_RESET;
      softClr <= 1'b0;
    end else begin
      softClr <= regWrite && regHit(regAddr, ddsw_pkg::REG_CTRL) &&
                 regWrData[ddsw_pkg::CTRL_SOFT_CLR_BIT];
      if (regWrite && regHit(regAddr, ddsw_pkg::REG_CTRL)) begin
        linkEn_reg <= regWrData[ddsw_pkg::CTRL_LINK_EN_BIT];
      end
    end
  end

  // sticky flags, write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (srst) begin
      leadErr_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      if (frameDone && frame.leadBitHi && frameMode != ddsw_pkg::MODE_POWER_DOWN) begin
        leadErr_reg <= 1'b1;
      end else if (regWrite && regHit(regAddr, ddsw_pkg::REG_STATUS) &&
                   regWrData[ddsw_pkg::ST_LEAD_ERR_BIT]) begin
        leadErr_reg <= 1'b0;
      end
      if (frameAbort) begin
        abort_reg <= 1'b1;
      end else if (regWrite && regHit(regAddr, ddsw_pkg::REG_STATUS) &&
                   regWrData[ddsw_pkg::ST_ABORT_BIT]) begin
        abort_reg <= 1'b0;
      end
    end
  end

  // executed frame count, for software to see traffic arrive
  always_ff @(posedge clk) begin
    if (srst) begin
      frames_reg <= '0;
    end else if (frameDone) begin
      frames_reg <= frames_reg + 16'h0001;
    end
  end

  // read multiplexer; unmapped offsets read as zero
  always_comb begin
    rdMux = '0;
    if (regHit(regAddr, ddsw_pkg::REG_CTRL)) begin
      rdMux[ddsw_pkg::CTRL_LINK_EN_BIT] = linkEn_reg;
    end else if (regHit(regAddr, ddsw_pkg::REG_STATUS)) begin
      rdMux[ddsw_pkg::ST_PD_BIT] = pd_reg;
      rdMux[ddsw_pkg::ST_TERM_LSB +: 2] = term_reg;
      rdMux[ddsw_pkg::ST_WAKE_BIT] = wakeRun;
      rdMux[ddsw_pkg::ST_LEAD_ERR_BIT] = leadErr_reg;
      rdMux[ddsw_pkg::ST_ABORT_BIT] = abort_reg;
      rdMux[ddsw_pkg::ST_STATE_LSB +: 2] = state_reg;
    end else if (regHit(regAddr, ddsw_pkg::REG_INPUT_FIRST)) begin
      rdMux[7:0] = inFirst_reg;
    end else if (regHit(regAddr, ddsw_pkg::REG_INPUT_SECOND)) begin
      rdMux[7:0] = inSecond_reg;
    end else if (regHit(regAddr, ddsw_pkg::REG_OUTPUT_FIRST)) begin
      rdMux[7:0] = outFirst_reg;
    end else if (regHit(regAddr, ddsw_pkg::REG_OUTPUT_SECOND)) begin
      rdMux[7:0] = outSecond_reg;
    end else if (regHit(regAddr, ddsw_pkg::REG_FRAMES)) begin
      rdMux = frames_reg;
    end
  end

  // read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_reg <= '0;
    end else begin
      rdData_reg <= regRead ? rdMux : '0;
    end
  end

  // the serial clock is sampled, not used as a clock: its rate is bounded
  // by four clk periods per bit period, well below the link's top rate
  assign regRdData = rdData_reg;
  assign analogOutputFirst = outFirst_reg;
  assign analogOutputSecond = outSecond_reg;
  assign powerDown = pd_reg;
  assign termSelect = term_reg;
  assign wakeBusy = wakeRun;

endmodule

`default_nettype wire

/* verilog/ddsw_wake_timer.sv */
// counts the wake interval after the outputs leave power-down
// assumes start is a one-cycle pulse on clk; a new start restarts the count
`default_nettype none

module ddsw_wake_timer #(
  parameter int CYCLES = 600
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic start,
  input wire logic abort,
  // state
  output logic busy
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  if (CYCLES < 1) begin : g_chk
    $error("ddsw_wake_timer: CYCLES must be at least 1");
  end

  logic [CW-1:0] count_reg; // cycles left
  logic busy_reg;

  // load on start, count down to zero, then drop busy
  always_ff @(posedge clk) begin
    if (srst || abort) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
    end else if (start) begin
      count_reg <= LOAD;
      busy_reg <= 1'b1;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
      busy_reg <= (count_reg != CW'(1));
    end
  end

  assign busy = busy_reg;

endmodule

`default_nettype wire
